// File: hw/count_cell.sv
// Counter register with synchronous clear and step
`timescale 1ns/100ps
module count_cell #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic clr,
	input wire logic inc,
	// Count
	output logic [W-1:0] cnt
);
	typedef struct packed {
		logic [W-1:0] cnt;
	} cell_t;
	cell_t s_reg;
	cell_t s_next;

	always_comb begin
		s_next = s_reg;
		// Clear wins over a step in the same cycle
		if (clr) begin
			s_next.cnt = '0;
		end else if (inc) begin
			s_next.cnt = s_reg.cnt + 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign cnt = s_reg.cnt;
endmodule

// File: hw/dual_timer.sv
// Dual 8-bit timer/event counter with capture, compare output and PWM
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
module dual_timer
	import timer_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register port
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rdata,
	// Pins
	input wire logic external_event_clock,
	input wire logic capture_trigger_a,
	input wire logic capture_trigger_b,
	output logic event_pin_input_sel,
	output logic first_out,
	output logic first_out_oe,
	output logic second_out,
	output logic second_out_oe,
	// Interrupt requests
	output logic first_irq,
	output logic second_irq
);
	typedef struct packed {
		logic [7:0] ctrl0;
		logic [7:0] first_compare_value;
		logic [7:0] first_capture_value;
		logic [7:0] ctrl1;
		logic [7:0] second_compare_value;
		logic [7:0] second_capture_value;
		logic [7:0] pwm_period_low;
		logic [7:0] pwm_duty_low;
		logic second_output_pin_enable;
		logic [3:0] pwm_high_bits;
		logic run0;
		logic run1;
		logic [PRESC_W-1:0] presc;
		logic [2:0] ext_s;
		logic [2:0] ta_s;
		logic [2:0] tb_s;
		logic m0_prev;
		logic m1_prev;
		logic irq0;
		logic irq1;
		logic out0;
		logic out1;
		logic [7:0] rdata;
	} state_t;
	state_t s_reg;
	state_t s_next;

	logic [7:0] c0;
	logic [PWM_W-1:0] c1;
	logic clr0, inc0, clr1, inc1;
	logic [2:0] first_clock_select;
	logic [1:0] second_clock_select;
	logic width_combine_select, pwm_mode_enable, first_capture_mode, second_capture_mode;
	logic pwm_polarity;
	logic ext_edge, ta_edge, tb_edge;
	logic tick0, tick1, en0, en1, step0, step1;
	logic start0, start1, stop0, capa, capb;
	logic m16, full16, m0, m1, wrap1;
	logic [15:0] c16;
	logic [PWM_W-1:0] period10, duty10;
	logic pwm_lvl;

	////////////////////////////////////////////////////////////////////////////////
	// Mode decode

	assign first_clock_select = s_reg.ctrl0[C0_CKS_HI:C0_CKS_LO];
	assign second_clock_select = s_reg.ctrl1[C1_CKS_HI:C1_CKS_LO];
	assign width_combine_select = s_reg.ctrl1[C1_COMB];
	assign pwm_mode_enable = s_reg.ctrl1[C1_PWM];
	assign first_capture_mode = s_reg.ctrl0[C0_CAP];
	assign second_capture_mode = s_reg.ctrl1[C1_CAP];
	assign pwm_polarity = s_reg.ctrl1[C1_POL];
	assign period10 = {s_reg.pwm_high_bits[H_PER_HI:H_PER_LO], s_reg.pwm_period_low};
	assign duty10 = {s_reg.pwm_high_bits[H_DUTY_HI:H_DUTY_LO], s_reg.pwm_duty_low};

	// Edges are taken from the second and third stages only
	assign ext_edge = s_reg.ext_s[1] & ~s_reg.ext_s[2];
	assign ta_edge = s_reg.ta_s[1] & ~s_reg.ta_s[2];
	assign tb_edge = s_reg.tb_s[1] & ~s_reg.tb_s[2];

	////////////////////////////////////////////////////////////////////////////////
	// Clock selection

	always_comb begin
		if (first_clock_select == CKS0_EXT) begin
			tick0 = ext_edge;
		end else begin
			tick0 = (s_reg.presc & DIV0_MASK[first_clock_select])
				== DIV0_MASK[first_clock_select];
		end
	end

	// No path from the event pin except through the first timer's tick
	always_comb begin
		unique case (second_clock_select)
			CKS1_DIV1: tick1 = 1'b1;
			CKS1_DIV2: tick1 = (s_reg.presc & DIV2_MASK) == DIV2_MASK;
			CKS1_DIV16: tick1 = (s_reg.presc & DIV16_MASK) == DIV16_MASK;
			CKS1_CHAIN: tick1 = tick0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Counting, matching and capture

	assign start0 = wr_en && addr == A_CTRL0 && wdata[C_START];
	assign stop0 = wr_en && addr == A_CTRL0 && !wdata[C_START];
	assign start1 = wr_en && addr == A_CTRL1 && wdata[C_START];
	assign en0 = s_reg.ctrl0[C0_EN] & s_reg.ctrl0[C_CONT] & s_reg.run0;
	assign en1 = s_reg.ctrl1[C_CONT] & s_reg.run1;
	assign step0 = tick0 & en0;
	assign step1 = tick1 & en1;
	assign c16 = {c1[7:0], c0};
	assign m16 = c16 == {s_reg.second_compare_value, s_reg.first_compare_value};
	assign full16 = &c16;
	assign capa = first_capture_mode & ta_edge;
	assign capb = !width_combine_select & second_capture_mode & tb_edge;
	assign m0 = s_reg.run0 & (width_combine_select ? m16 : c0 == s_reg.first_compare_value);
	assign m1 = s_reg.run1 & !width_combine_select & !pwm_mode_enable
		& c1 == {2'b00, s_reg.second_compare_value};

	always_comb begin
		if (pwm_mode_enable) begin
			wrap1 = period10 == PWM_ZERO || c1 >= period10 - PWM_ONE;
		end else begin
			wrap1 = c1[7:0] == s_reg.second_compare_value || &c1[7:0];
		end
	end

	always_comb begin
		if (width_combine_select) begin
			// Both bytes clear together on the joined match
			clr0 = start0 | capa | (step0 & (m16 | full16));
			inc0 = step0;
			clr1 = clr0;
			inc1 = step0 & (c0 == BYTE_FULL);
		end else begin
			clr0 = start0 | capa | (step0 & c0 == s_reg.first_compare_value);
			inc0 = step0;
			clr1 = start1 | capb | (step1 & wrap1);
			inc1 = step1;
		end
	end

	count_cell #(.W(8)) first_cell (
		.clk(clk),
		.rst_n(rst_n),
		.clr(clr0),
		.inc(inc0),
		.cnt(c0)
	);

	count_cell #(.W(PWM_W)) second_cell (
		.clk(clk),
		.rst_n(rst_n),
		.clr(clr1),
		.inc(inc1),
		.cnt(c1)
	);

	// Duty part shows the polarity level, so the end cases fall out directly
	assign pwm_lvl = (c1 < duty10) ? pwm_polarity : ~pwm_polarity;

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		s_next = s_reg;
		s_next.presc = s_reg.presc + 1'b1;
		s_next.ext_s = {s_reg.ext_s[1:0], external_event_clock};
		s_next.ta_s = {s_reg.ta_s[1:0], capture_trigger_a};
		s_next.tb_s = {s_reg.tb_s[1:0], capture_trigger_b};
		s_next.m0_prev = m0;
		s_next.m1_prev = m1;
		s_next.irq0 = m0 & !s_reg.m0_prev;
		s_next.irq1 = m1 & !s_reg.m1_prev;
		if (s_next.irq0) begin
			s_next.out0 = ~s_reg.out0;
		end
		if (pwm_mode_enable) begin
			s_next.out1 = pwm_lvl;
		end else if (s_next.irq1) begin
			s_next.out1 = ~s_reg.out1;
		end
		if (capa) begin
			s_next.first_capture_value = c0;
			if (width_combine_select) begin
				s_next.second_capture_value = c1[7:0];
			end
		end
		if (capb) begin
			s_next.second_capture_value = c1[7:0];
		end
		if (wr_en) begin
			unique case (addr)
				A_CTRL0: begin
					s_next.ctrl0 = wdata;
					s_next.run0 = wdata[C_START];
				end
				A_DATA0: s_next.first_compare_value = wdata;
				A_CTRL1: begin
					s_next.ctrl1 = wdata;
					s_next.run1 = wdata[C_START];
				end
				A_DATA1: begin
					if (pwm_mode_enable) begin
						s_next.pwm_period_low = wdata;
					end else begin
						s_next.second_compare_value = wdata;
					end
				end
				A_DUTY1: begin
					if (pwm_mode_enable) begin
						s_next.pwm_duty_low = wdata;
					end
				end
				A_HIGH1: begin
					s_next.second_output_pin_enable = wdata[H_PE];
					s_next.pwm_high_bits = wdata[H_PER_HI:H_DUTY_LO];
				end
				default: ;
			endcase
		end
		s_next.rdata = BYTE_ZERO;
		if (rd_en) begin
			unique case (addr)
				A_CTRL0: s_next.rdata = {s_reg.ctrl0[7:1], s_reg.run0};
				A_DATA0: s_next.rdata = first_capture_mode ? s_reg.first_capture_value : c0;
				A_CTRL1: s_next.rdata = {s_reg.ctrl1[7:1], s_reg.run1};
				A_DUTY1: begin
					if (second_capture_mode) begin
						s_next.rdata = s_reg.second_capture_value;
					end else if (pwm_mode_enable) begin
						s_next.rdata = s_reg.pwm_duty_low;
					end else begin
						s_next.rdata = c1[7:0];
					end
				end
				default: s_next.rdata = BYTE_ZERO;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
			s_reg.first_compare_value <= CMP_RST;
			s_reg.second_compare_value <= CMP_RST;
			s_reg.pwm_period_low <= PER_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign rdata = s_reg.rdata;
	assign event_pin_input_sel = first_clock_select == CKS0_EXT;
	assign first_out = s_reg.out0;
	assign first_out_oe = s_reg.ctrl0[C0_PE];
	assign second_out = s_reg.out1;
	assign second_out_oe = s_reg.second_output_pin_enable;
	assign first_irq = s_reg.irq0;
	assign second_irq = s_reg.irq1;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	AST_START_CLEARS: assert property (
		start0 |=> c0 == BYTE_ZERO && s_reg.run0)
		else $error("start write did not clear and run the first counter");
	AST_STOP_HALTS: assert property (
		stop0 |=> !s_reg.run0 ##1 ($stable(c0) || $past(clr0)))
		else $error("stop write did not halt the first counter");
	AST_DIV2_TICK: assert property (
		first_clock_select == 3'h0 |-> tick0 == s_reg.presc[0])
		else $error("first divide by two tick wrong");
	AST_SECOND_DIV16: assert property (
		second_clock_select == CKS1_DIV16 && $stable(second_clock_select) && tick1
		|-> $past(tick1, 1) == 1'b0
		&& s_reg.presc[3:0] == 4'hf)
		else $error("second divide by sixteen tick wrong");
	AST_EVENT_STEP: assert property (
		first_clock_select == CKS0_EXT && ext_edge && en0 && !clr0
		|=> c0 == $past(c0) + 8'h01)
		else $error("event edge did not advance the first counter");
	AST_MATCH_WRAP: assert property (
		!width_combine_select && step0 && c0 == s_reg.first_compare_value
		|=> c0 == BYTE_ZERO ##1 first_irq == 1'b0)
		else $error("first counter did not wrap after match");
	AST_JOINED_WRAP: assert property (
		width_combine_select && step0 && m16 |=> c16 == 16'h0000)
		else $error("joined counter did not return to zero");
	AST_JOINED_NO_SECOND: assert property (
		width_combine_select && $past(width_combine_select) |-> !second_irq)
		else $error("second interrupt raised in joined mode");
	AST_MATCH_IRQ: assert property (
		!width_combine_select && s_reg.run0 && $rose(c0 == s_reg.first_compare_value)
		&& $stable(s_reg.first_compare_value) |=> first_irq)
		else $error("first match raised no interrupt");
	AST_CAPTURE: assert property (
		capa |=> s_reg.first_capture_value == $past(c0) && c0 == BYTE_ZERO)
		else $error("capture did not copy and clear");
	AST_CAPTURE_READ: assert property (
		rd_en && addr == A_DATA0 && first_capture_mode && !capa
		|=> rdata == s_reg.first_capture_value)
		else $error("capture mode read did not return capture data");
	AST_PWM_FULL: assert property (
		pwm_mode_enable && duty10 == period10 && period10 != PWM_ZERO
		&& $stable(pwm_polarity) |=> second_out == $past(pwm_polarity))
		else $error("full duty did not hold polarity level");
	AST_PWM_ZERO: assert property (
		pwm_mode_enable && duty10 == PWM_ZERO && $stable(pwm_polarity)
		|=> second_out == !$past(pwm_polarity))
		else $error("zero duty did not hold inverse level");
endmodule

// File: shared/timer_pkg.sv
// Constants for the dual 8-bit timer with capture and PWM
// Behaviour
// - Two 8-bit counters run alone or join into one 16-bit counter.
// - First clock select: system clock /2,/4,/16,/64,/256,/1024,/4096 or event pin.
// - Second clock select: system clock /1, /2, /16, or the first timer's clock.
// - The second timer never takes the event pin directly.
// - Counters step on their clock; equality with compare raises that timer's interrupt.
// - Event clock selected: its pin is an input, counting on each rising edge.
// - Joined: first counter is the low byte, second the high byte.
// - Joined counter counts up to the joined compare value, then returns to zero.
// - Joined match raises only the first interrupt, never the second.
// - Capture mode: trigger copies the running count into the capture register.
// - After capture the count clears and restarts; compare interrupts still occur.
// - Capture mode: the shared counter address reads the capture register.
// - Joined capture takes and clears the whole 16-bit count.
// - PWM mode drives the second output pin, up to 10 bits, pin enable needed.
// - Period and duty are 10-bit: high register bits above the 8-bit registers.
// - Duty equal to period holds the output at the polarity level.
// - Duty zero holds the output at the inverse of the polarity level.
// - Polarity bit selects which level the duty part of the period shows.
// - Start bit one clears the counter and runs; zero stops it.
package timer_pkg;
	localparam logic [7:0] A_CTRL0 = 8'hb2;
	localparam logic [7:0] A_DATA0 = 8'hb3;
	localparam logic [7:0] A_CTRL1 = 8'hb4;
	localparam logic [7:0] A_DATA1 = 8'hb5;
	localparam logic [7:0] A_DUTY1 = 8'hb6;
	localparam logic [7:0] A_HIGH1 = 8'hb7;
	// First control fields
	localparam int C0_EN = 7;
	localparam int C0_PE = 6;
	localparam int C0_CAP = 5;
	localparam int C0_CKS_HI = 4;
	localparam int C0_CKS_LO = 2;
	// Second control fields
	localparam int C1_POL = 7;
	localparam int C1_COMB = 6;
	localparam int C1_PWM = 5;
	localparam int C1_CAP = 4;
	localparam int C1_CKS_HI = 3;
	localparam int C1_CKS_LO = 2;
	// Shared control fields
	localparam int C_CONT = 1;
	localparam int C_START = 0;
	// High register fields
	localparam int H_PE = 7;
	localparam int H_PER_HI = 3;
	localparam int H_PER_LO = 2;
	localparam int H_DUTY_HI = 1;
	localparam int H_DUTY_LO = 0;
	// Reset values and byte constants
	localparam logic [7:0] CMP_RST = 8'hff;
	localparam logic [7:0] PER_RST = 8'hff;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] BYTE_FULL = 8'hff;
	// Clock source codes
	localparam logic [2:0] CKS0_EXT = 3'h7;
	localparam logic [1:0] CKS1_DIV1 = 2'h0;
	localparam logic [1:0] CKS1_DIV2 = 2'h1;
	localparam logic [1:0] CKS1_DIV16 = 2'h2;
	localparam logic [1:0] CKS1_CHAIN = 2'h3;
	// Prescaler: a divide by 2^k ticks when the low k bits are all ones
	localparam int PRESC_W = 12;
	localparam logic [PRESC_W-1:0] DIV0_MASK [7] = '{12'h001, 12'h003, 12'h00f, 12'h03f,
		12'h0ff, 12'h3ff, 12'hfff};
	localparam logic [PRESC_W-1:0] DIV2_MASK = 12'h001;
	localparam logic [PRESC_W-1:0] DIV16_MASK = 12'h00f;
	localparam int PWM_W = 10;
	localparam logic [PWM_W-1:0] PWM_ZERO = 10'h000;
	localparam logic [PWM_W-1:0] PWM_ONE = 10'h001;
endpackage

// File: test/pin_model.sv
// Pin-side model: event clock and capture trigger sources
`timescale 1ns/100ps
module pin_model (
	// Clock
	input wire logic clk,
	// Pins
	output logic external_event_clock,
	output logic capture_trigger_a,
	output logic capture_trigger_b
);
	initial begin
		external_event_clock = 1'b0;
		capture_trigger_a = 1'b0;
		capture_trigger_b = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// Four high, four low: well slower than the two-flop synchroniser
	task automatic pulse(input int which);
		@(posedge clk);
		case (which)
			0: external_event_clock <= 1'b1;
			1: capture_trigger_a <= 1'b1;
			default: capture_trigger_b <= 1'b1;
		endcase
		repeat (4) @(posedge clk);
		external_event_clock <= 1'b0;
		capture_trigger_a <= 1'b0;
		capture_trigger_b <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
endmodule

// File: test/tb.sv
// Self-checking bench for the dual timer
`timescale 1ns/100ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin errors++; \
	$display("BAD %0t got %0h want %0h", $time, (a), (e)); end end
module tb;
	import timer_pkg::*;
	logic clk;
	logic rst_n;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic wr_en;
	logic rd_en;
	logic [7:0] rdata;
	logic ev, trig_a, trig_b;
	logic pin_sel, f_out, f_oe, s_out, s_oe, f_irq, s_irq;
	int errors = 0;
	int check_count = 0;
	int s_irq_n = 0;
	int f_irq_n = 0;
	int f_tog = 0;
	int s_tog = 0;
	logic f_last = 1'b0;
	logic s_last = 1'b0;
	logic [7:0] d;
	int gap, hi, i;
	int divs [7] = '{2, 4, 16, 64, 256, 1024, 4096};
	int d1 [4] = '{1, 2, 16, 4};
	logic [7:0] pw [5][4] = '{'{8'h80, 8'h00, 8'h40, 8'd64}, '{8'h00, 8'h00, 8'h40, 8'd196},
		'{8'h80, 8'h01, 8'h04, 8'd4}, '{8'h80, 8'h00, 8'h00, 8'd0},
		'{8'h00, 8'h00, 8'h00, 8'd4}};
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	dual_timer DUT (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(rdata), .external_event_clock(ev), .capture_trigger_a(trig_a),
		.capture_trigger_b(trig_b), .event_pin_input_sel(pin_sel), .first_out(f_out),
		.first_out_oe(f_oe), .second_out(s_out), .second_out_oe(s_oe), .first_irq(f_irq),
		.second_irq(s_irq));
	pin_model pins (.clk(clk), .external_event_clock(ev), .capture_trigger_a(trig_a),
		.capture_trigger_b(trig_b));
	always @(negedge clk) begin
		if (s_irq === 1'b1) begin
			s_irq_n++;
		end
		if (f_irq === 1'b1) begin
			f_irq_n++;
		end
		// Compare outputs toggle once per interrupt
		if (f_out !== f_last) begin
			f_tog++;
		end
		if (s_out !== s_last) begin
			s_tog++;
		end
		f_last = f_out;
		s_last = s_out;
	end
	////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
		// Let the write settle before callers look at outputs
		#1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 v = rdata;
	endtask
	// Cycles between two interrupt pulses; bounded so a dead timer cannot hang
	task automatic irq_gap(input int which, output int n);
		int k;
		@(negedge clk);
		for (k = 0; k < 30000 && ((which ? s_irq : f_irq) !== 1'b1); k++) @(negedge clk);
		@(negedge clk);
		n = 1;
		while (((which ? s_irq : f_irq) !== 1'b1) && n < 30000) begin
			@(negedge clk);
			n++;
		end
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		#360000;
		errors++;
		test_done();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		rst_n <= 1'b0;
		addr <= 8'h00;
		wdata <= 8'h00;
		wr_en <= 1'b0;
		rd_en <= 1'b0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		foreach (pw[k]) begin
			rd(8'hb2 + k[7:0], d);
			`CHK(d, BYTE_ZERO)
		end
		rd(8'h10, d);
		`CHK(d, BYTE_ZERO)
		// Prescaled first timer: gap is (compare + 1) * divisor
		wr(A_DATA0, 8'h04);
		for (i = 0; i < 7; i++) begin
			wr(A_CTRL0, 8'hc3 | 8'(i << 2));
			`CHK(pin_sel, 1'b0)
			`CHK(f_oe, 1'b1)
			irq_gap(0, gap);
			`CHK(gap, 5 * divs[i])
		end
		// Second timer sources; code 3 follows the first timer at /4
		// First timer held, its prescaler tick still drives the chain
		wr(A_CTRL0, 8'h86);
		wr(A_DATA0, 8'hff);
		wr(A_DATA1, 8'h10);
		for (i = 0; i < 4; i++) begin
			wr(A_CTRL1, 8'h03 | 8'(i << 2));
			irq_gap(1, gap);
			`CHK(gap, 17 * d1[i])
		end
		// Joined: compare 0x0104 at /2, first interrupt only
		wr(A_DATA0, 8'h04);
		wr(A_DATA1, 8'h01);
		wr(A_CTRL1, 8'h4e);
		wr(A_CTRL0, 8'h83);
		hi = s_irq_n;
		irq_gap(0, gap);
		`CHK(gap, 522)
		`CHK(s_irq_n, hi)
		// Event counting, stop and restart-clear
		wr(A_CTRL1, 8'h00);
		wr(A_DATA0, 8'h40);
		wr(A_DATA1, 8'h40);
		wr(A_CTRL0, 8'h9f);
		`CHK(pin_sel, 1'b1)
		repeat (3) pins.pulse(0);
		rd(A_DATA0, d);
		`CHK(d, 8'h03)
		wr(A_CTRL0, 8'h9e);
		repeat (2) pins.pulse(0);
		rd(A_DATA0, d);
		`CHK(d, 8'h03)
		wr(A_CTRL0, 8'h9f);
		rd(A_DATA0, d);
		`CHK(d, 8'h00)
		// Capture on both timers, second chained to the event-clocked first
		wr(A_CTRL1, 8'h1f);
		wr(A_CTRL0, 8'hbf);
		repeat (3) pins.pulse(0);
		pins.pulse(1);
		pins.pulse(2);
		rd(A_DATA0, d);
		`CHK(d, 8'h03)
		rd(A_DUTY1, d);
		`CHK(d, 8'h03)
		repeat (2) pins.pulse(0);
		pins.pulse(1);
		rd(A_DATA0, d);
		`CHK(d, 8'h02)
		rd(A_DUTY1, d);
		`CHK(d, 8'h03)
		// Joined capture of the whole count, 0x0105 so both bytes matter
		wr(A_CTRL1, 8'h5e);
		wr(A_CTRL0, 8'hbf);
		repeat (261) pins.pulse(0);
		pins.pulse(1);
		rd(A_DATA0, d);
		`CHK(d, 8'h05)
		rd(A_DUTY1, d);
		`CHK(d, 8'h01)
		`CHK(s_tog, s_irq_n)
		// PWM, period 0x104 every cycle; high cycles counted over one period
		wr(A_CTRL0, 8'h00);
		`CHK(s_oe, 1'b0)
		foreach (pw[k]) begin
			wr(A_CTRL1, pw[k][0] | 8'h23);
			wr(A_DATA1, 8'h04);
			wr(A_HIGH1, 8'h84 | pw[k][1]);
			wr(A_DUTY1, pw[k][2]);
			repeat (600) @(negedge clk);
			hi = 0;
			repeat (260) begin
				@(negedge clk);
				hi += (s_out === 1'b1);
			end
			`CHK(s_oe, 1'b1)
			`CHK(hi, (pw[k][3] == 8'd4) ? 260 : int'(pw[k][3]))
		end
		`CHK(f_tog, f_irq_n)
		test_done();
	end
endmodule
